// *** pkg/imt_pkg.sv ***
// Constants, status codes and state types for the two-wire master transmit sequencer
package imt_pkg;
  // System clock period and bus phase times in ns
  localparam int CLK_NS = 40;
  localparam int T_HALF_NS = 5000;
  localparam int T_BUF_NS = 4700;
  localparam int CNT_W = 8;
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'((T_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] BUF_CNT = CNT_W'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] SETUP_CNT = 8'h02;
  // Bit slots within a byte
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Address patterns
  localparam logic [4:0] TENBIT_TAG = 5'h1e;
  localparam logic [6:0] GC_ADDR = 7'h00;
  // Status codes
  localparam logic [7:0] CODE_IDLE = 8'hf8;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RSTART = 8'h10;
  localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_DATA_ACK = 8'h28;
  localparam logic [7:0] CODE_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB = 8'h38;
  localparam logic [7:0] CODE_SL_RX = 8'h68;
  localparam logic [7:0] CODE_GCALL = 8'h78;
  localparam logic [7:0] CODE_SRX_ACK = 8'h80;
  localparam logic [7:0] CODE_SRX_NACK = 8'h88;
  localparam logic [7:0] CODE_SL_TX = 8'hb0;
  localparam logic [7:0] CODE_STX_ACK = 8'hb8;
  localparam logic [7:0] CODE_STX_LAST = 8'hc8;
  localparam logic [7:0] CODE_XADDR_ACK = 8'hd0;
  localparam logic [7:0] CODE_XADDR_NACK = 8'hd8;
  // Sequencer states, Gray from ST_IDLE to ST_BIT_HIGH; ST_BIT_HIGH back to ST_BIT_LOW flips two bits
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_WAIT_FREE = 4'h1, ST_START_A = 4'h3, ST_START_B = 4'h2,
    ST_HOLD = 4'h6, ST_BIT_LOW = 4'h7, ST_BIT_RISE = 4'h5, ST_BIT_HIGH = 4'h4,
    ST_STOP_A = 4'hc, ST_STOP_B = 4'hd, ST_RS_A = 4'hf, ST_RS_B = 4'he
  } imt_state_e;
  // Kind of byte being moved
  typedef enum logic [2:0] {
    K_ADDR = 3'h0, K_XADDR = 3'h1, K_DATA = 3'h2, K_SRX = 3'h3, K_STX = 3'h4
  } imt_kind_e;
endpackage

// *** logic/imt_sequencer.sv ***
// Two-wire bus master transmit sequencer with arbitration fallback to slave
// How it works
// - Begin request waits for free bus, sends START
// - After START set flag, post 08h
// - No progress while flag set; software clears
// - After address post 18h ack, 20h nack
// - After 18h/20h: byte, restart, stop, both
// - Ten-bit second address byte posts D0h/D8h
// - Arbitration lost posts 38h; idle or restart
// - Own write address 68h, general call 78h
// - Own read address posts B0h, send bytes
// - Repeated START posts 10h instead of 08h
// - Data byte posts 28h/30h, loss 38h
// - After 28h/30h: byte, restart, stop, both
// - Stop request sends STOP, self-clears, idles
// - Acknowledge enable picks ACK or NACK
// - Address loss switches to slave recognition
`timescale 1ns/1ps
module imt_sequencer (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic begin_set_in,
  input wire logic stop_set_in,
  input wire logic flag_clear_in,
  input wire logic byte_wr_in,
  input wire logic [7:0] byte_in,
  input wire logic acknowledge_enable_in,
  input wire logic general_call_enable_in,
  input wire logic [6:0] own_address_in,
  output logic begin_condition_request_out,
  output logic stop_condition_request_out,
  output logic transfer_event_flag_out,
  output logic irq_out,
  output logic [7:0] state_code_out,
  output logic [7:0] rx_byte_out,
  output logic bus_busy_out
);
  import imt_pkg::*;

  imt_state_e state_reg, state_next;
  imt_kind_e kind_reg, kind_next;
  logic [imt_pkg::CNT_W-1:0] cnt_reg, cnt_next, free_reg, free_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] code_reg, post_code, byte_reg, tx_sh_reg, rx_sh_reg, slv_code_reg, slv_code_next;
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg, sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic flag_reg, sta_reg, stp_reg, busy_reg, master_reg, slave_reg, rs_reg, ten_reg;
  logic master_next, slave_next, rs_next, ten_next;
  logic ack_drv_reg, ack_drv_next, ack_rx_reg, ack_rx_next;
  logic scl_oe_n_reg, sda_oe_n_reg, scl_low_next, sda_low_next;
  logic post, sta_clr, stp_clr, load_tx, shift_in, arb_lost;

  // Pin sampling: two flops before use, third for edge history
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {scl_in, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {sda_in, sda_s1_reg, sda_s2_reg};
    end
  end

  // Bus conditions seen on the wires, ours included
  wire start_seen = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  wire stop_seen = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
  wire bus_free = (free_reg == BUF_CNT);
  wire half_done = (cnt_reg == HALF_CNT);
  // Slave follows the other master's clock instead of timing the high phase
  wire high_done = master_reg ? half_done : ~scl_s2_reg;
  wire byte_end = (state_reg == ST_BIT_HIGH) && (bit_reg == BIT_ACK) && high_done;
  wire tx_kind = (kind_reg == K_ADDR) || (kind_reg == K_XADDR) || (kind_reg == K_DATA);
  wire tx_active = (kind_reg == K_STX) || (master_reg && tx_kind);
  wire tx_one = tx_active && (bit_reg != BIT_ACK) && tx_sh_reg[7];
  wire [7:0] byte_now = {rx_sh_reg[6:0], sda_s2_reg};
  wire addr_hit = (byte_now[7:1] == own_address_in);
  wire gc_hit = (byte_now[7:1] == GC_ADDR) && !byte_now[0] && general_call_enable_in;
  wire code_after_addr = (code_reg == CODE_ADDR_ACK) || (code_reg == CODE_ADDR_NACK);
  wire ten_tag = (byte_reg[7:3] == TENBIT_TAG);
  wire timed_wait = (state_reg == ST_RS_B) || (state_reg == ST_STOP_B);

  // Sequencer next state and side effects
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    bit_next = bit_reg;
    post = 1'b0;
    post_code = code_reg;
    master_next = master_reg;
    slave_next = slave_reg;
    rs_next = rs_reg;
    ten_next = ten_reg;
    sta_clr = 1'b0;
    stp_clr = 1'b0;
    load_tx = 1'b0;
    shift_in = 1'b0;
    arb_lost = 1'b0;
    ack_drv_next = ack_drv_reg;
    ack_rx_next = ack_rx_reg;
    slv_code_next = slv_code_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sta_reg) state_next = ST_WAIT_FREE;
      end
      ST_WAIT_FREE: begin
        if (bus_free) begin
          state_next = ST_START_A;
          master_next = 1'b1;
          slave_next = 1'b0;
          rs_next = 1'b0;
          sta_clr = 1'b1;
        end
      end
      ST_START_A: begin
        if (half_done) state_next = ST_START_B;
      end
      ST_START_B: begin
        if (half_done) begin
          state_next = ST_HOLD;
          post = 1'b1;
          post_code = rs_reg ? CODE_RSTART : CODE_START;
        end
      end
      ST_HOLD: begin
        if (!flag_reg) begin
          bit_next = '0;
          case (code_reg)
            CODE_START, CODE_RSTART: begin
              kind_next = K_ADDR;
              load_tx = 1'b1;
              ten_next = ten_tag;
              state_next = ST_BIT_LOW;
            end
            CODE_ADDR_ACK, CODE_ADDR_NACK, CODE_XADDR_ACK, CODE_XADDR_NACK, CODE_DATA_ACK, CODE_DATA_NACK: begin
              // Both requests: STOP first, the pending begin then sends a new START (08h), not a repeated one
              if (stp_reg) state_next = ST_STOP_A;
              else if (sta_reg) state_next = ST_RS_A;
              else begin
                load_tx = 1'b1;
                kind_next = (ten_reg && code_after_addr) ? K_XADDR : K_DATA;
                state_next = ST_BIT_LOW;
              end
            end
            CODE_SL_RX, CODE_GCALL, CODE_SRX_ACK, CODE_SRX_NACK: begin
              kind_next = K_SRX;
              state_next = ST_BIT_LOW;
            end
            CODE_SL_TX, CODE_STX_ACK: begin
              kind_next = K_STX;
              load_tx = 1'b1;
              state_next = ST_BIT_LOW;
            end
            default: begin
              state_next = sta_reg ? ST_WAIT_FREE : ST_IDLE;
              master_next = 1'b0;
              slave_next = 1'b0;
            end
          endcase
        end
      end
      ST_BIT_LOW: begin
        if (master_reg ? half_done : (cnt_reg == SETUP_CNT)) state_next = ST_BIT_RISE;
      end
      ST_BIT_RISE: begin
        if (scl_s2_reg) begin
          state_next = ST_BIT_HIGH;
          shift_in = (bit_reg != BIT_ACK);
          if (bit_reg == BIT_ACK) ack_rx_next = ~sda_s2_reg;
          if (bit_reg == BIT_LAST) begin
            if (kind_reg == K_SRX) ack_drv_next = acknowledge_enable_in;
            else if (kind_reg == K_ADDR && !master_reg) ack_drv_next = addr_hit | gc_hit;
            else ack_drv_next = 1'b0;
            slv_code_next = addr_hit ? (byte_now[0] ? CODE_SL_TX : CODE_SL_RX) : CODE_GCALL;
          end
          if (master_reg && tx_one && !sda_s2_reg) begin
            arb_lost = 1'b1;
            master_next = 1'b0;
            if (kind_reg == K_ADDR) begin
              slave_next = 1'b1;
              if (bit_reg == BIT_LAST) ack_drv_next = addr_hit | gc_hit;
            end else begin
              state_next = ST_HOLD;
              post = 1'b1;
              post_code = CODE_ARB;
            end
          end
        end
      end
      ST_BIT_HIGH: begin
        if (high_done) begin
          if (bit_reg == BIT_ACK) begin
            state_next = ST_HOLD;
            post = 1'b1;
            case (kind_reg)
              K_ADDR: begin
                if (slave_reg) begin
                  post_code = ack_drv_reg ? slv_code_reg : CODE_ARB;
                  slave_next = ack_drv_reg;
                end else post_code = ack_rx_reg ? CODE_ADDR_ACK : CODE_ADDR_NACK;
              end
              K_XADDR: begin
                post_code = ack_rx_reg ? CODE_XADDR_ACK : CODE_XADDR_NACK;
                ten_next = 1'b0;
              end
              K_DATA: post_code = ack_rx_reg ? CODE_DATA_ACK : CODE_DATA_NACK;
              K_SRX: post_code = ack_drv_reg ? CODE_SRX_ACK : CODE_SRX_NACK;
              K_STX: post_code = ack_rx_reg ? CODE_STX_ACK : CODE_STX_LAST;
              default: post_code = CODE_ARB;
            endcase
          end else begin
            bit_next = bit_reg + 4'h1;
            state_next = ST_BIT_LOW;
          end
        end
      end
      ST_STOP_A: begin
        if (half_done) state_next = ST_STOP_B;
      end
      ST_STOP_B: begin
        if (half_done) begin
          state_next = sta_reg ? ST_WAIT_FREE : ST_IDLE;
          stp_clr = 1'b1;
          master_next = 1'b0;
        end
      end
      ST_RS_A: begin
        if (half_done) state_next = ST_RS_B;
      end
      ST_RS_B: begin
        if (half_done) begin
          state_next = ST_START_A;
          rs_next = 1'b1;
          sta_clr = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // A remote STOP ends a slave transfer in flight, except while it waits in ST_HOLD
    if (slave_reg && stop_seen && state_reg != ST_HOLD) begin
      state_next = ST_IDLE;
      slave_next = 1'b0;
    end
  end

  // Pin drive: open drain, so only the enables carry data
  always_comb begin
    scl_low_next = 1'b0;
    sda_low_next = 1'b0;
    case (state_reg)
      ST_START_A, ST_STOP_B: sda_low_next = 1'b1;
      ST_START_B, ST_STOP_A: begin
        scl_low_next = 1'b1;
        sda_low_next = 1'b1;
      end
      ST_RS_A: scl_low_next = 1'b1;
      ST_HOLD: scl_low_next = master_reg | slave_reg;
      ST_BIT_LOW: begin
        scl_low_next = master_reg | slave_reg;
        // Data moves one cycle after the clock fell, for hold time
        if (cnt_reg == '0) sda_low_next = ~sda_oe_n_reg;
        else sda_low_next = (bit_reg == BIT_ACK) ? ack_drv_reg : (tx_active & ~tx_sh_reg[7]);
      end
      ST_BIT_RISE, ST_BIT_HIGH: begin
        sda_low_next = (bit_reg == BIT_ACK) ? ack_drv_reg : (tx_active & ~tx_sh_reg[7]);
        if (arb_lost) sda_low_next = 1'b0;
      end
      default: begin
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
      end
    endcase
  end

  // Phase counter restarts on every state change; waits count only with SCL high
  assign cnt_next = ((state_next != state_reg) || (timed_wait && !scl_s2_reg)) ? '0 : cnt_reg + 8'h01;
  // Bus free timer: busy between START and STOP, then both lines high long enough
  assign free_next = (busy_reg || !scl_s2_reg || !sda_s2_reg) ? '0 : (bus_free ? free_reg : free_reg + 8'h01);

  // Sequencer registers
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      kind_reg <= K_ADDR;
      cnt_reg <= '0;
      bit_reg <= '0;
      master_reg <= 1'b0;
      slave_reg <= 1'b0;
      rs_reg <= 1'b0;
      ten_reg <= 1'b0;
      ack_drv_reg <= 1'b0;
      ack_rx_reg <= 1'b0;
      slv_code_reg <= CODE_ARB;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      master_reg <= master_next;
      slave_reg <= slave_next;
      rs_reg <= rs_next;
      ten_reg <= ten_next;
      ack_drv_reg <= ack_drv_next;
      ack_rx_reg <= ack_rx_next;
      slv_code_reg <= slv_code_next;
      scl_oe_n_reg <= ~scl_low_next;
      sda_oe_n_reg <= ~sda_low_next;
    end
  end

  // Software-facing bits: a set wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flag_reg <= 1'b0;
      code_reg <= CODE_IDLE;
      sta_reg <= 1'b0;
      stp_reg <= 1'b0;
      busy_reg <= 1'b0;
      free_reg <= '0;
    end else begin
      flag_reg <= post | (flag_reg & ~flag_clear_in);
      if (post) code_reg <= post_code;
      sta_reg <= begin_set_in | (sta_reg & ~sta_clr);
      stp_reg <= stop_set_in | (stp_reg & ~stp_clr);
      busy_reg <= start_seen | (busy_reg & ~stop_seen);
      free_reg <= free_next;
    end
  end

  // Byte paths; the software byte register is the only writer-loaded store
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      byte_reg <= '0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
    end else begin
      if (byte_wr_in) byte_reg <= byte_in;
      if (load_tx) tx_sh_reg <= byte_reg;
      else if (state_reg == ST_BIT_HIGH && high_done && bit_reg != BIT_ACK) tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      if (shift_in) rx_sh_reg <= byte_now;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = scl_oe_n_reg;
  assign sda_oe_n_out = sda_oe_n_reg;
  assign begin_condition_request_out = sta_reg;
  assign stop_condition_request_out = stp_reg;
  assign transfer_event_flag_out = flag_reg;
  assign irq_out = flag_reg;
  assign state_code_out = code_reg;
  assign rx_byte_out = rx_sh_reg;
  assign bus_busy_out = busy_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  AST_WAIT_BUS: assert property (state_reg == ST_WAIT_FREE && !bus_free |=> state_reg == ST_WAIT_FREE)
    else $error("left bus wait before bus free");
  AST_START_POST: assert property (state_reg == ST_START_B && half_done && !rs_reg
    |=> flag_reg && code_reg == CODE_START) else $error("START did not post 08h");
  AST_RSTART_POST: assert property (state_reg == ST_START_B && half_done && rs_reg
    |=> flag_reg && code_reg == CODE_RSTART) else $error("repeated START did not post 10h");
  AST_HOLD_STALL: assert property (state_reg == ST_HOLD && flag_reg |=> state_reg == ST_HOLD)
    else $error("advanced while flag set");
  AST_ADDR_POST: assert property (byte_end && kind_reg == K_ADDR && master_reg
    |=> flag_reg && code_reg == ($past(ack_rx_reg) ? CODE_ADDR_ACK : CODE_ADDR_NACK)) else $error("bad address code");
  AST_XADDR_POST: assert property (byte_end && kind_reg == K_XADDR
    |=> code_reg == ($past(ack_rx_reg) ? CODE_XADDR_ACK : CODE_XADDR_NACK)) else $error("bad ten-bit code");
  AST_DATA_POST: assert property (byte_end && kind_reg == K_DATA
    |=> flag_reg && code_reg == ($past(ack_rx_reg) ? CODE_DATA_ACK : CODE_DATA_NACK)) else $error("bad data code");
  AST_ARB_DATA: assert property (arb_lost && kind_reg != K_ADDR
    |=> flag_reg && code_reg == CODE_ARB && !master_reg ##1 sda_oe_n_out) else $error("data loss not posted");
  AST_ARB_SLAVE: assert property (arb_lost && kind_reg == K_ADDR
    |=> slave_reg && !master_reg ##1 sda_oe_n_out) else $error("address loss did not become slave");
  // A clear in the same cycle lets the flag drop, so only a standing flag is checked
  AST_SCL_HOLD: assert property (state_reg == ST_HOLD && flag_reg && master_reg && !flag_clear_in
    |=> !scl_oe_n_out && irq_out) else $error("clock not held during flag");
  AST_STOP_DONE: assert property (state_reg == ST_STOP_B && half_done && !stop_set_in
    |=> !stp_reg && !master_reg ##1 sda_oe_n_out) else $error("STOP did not finish");
  AST_ACK_CHOICE: assert property (state_reg == ST_BIT_RISE && scl_s2_reg && bit_reg == BIT_LAST && kind_reg == K_SRX
    |=> ack_drv_reg == $past(acknowledge_enable_in)) else $error("ack choice wrong");
endmodule

// *** verif/imt_slave_model.sv ***
// Behavioural slave receiver on the two-wire bus, with optional clock stretching
`timescale 1ns/1ps
module imt_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ack_en_in,
  input wire logic stretch_in,
  output logic scl_rel_out,
  output logic sda_rel_out,
  output logic [7:0] last_byte_out
);
  logic [7:0] sh;
  int cnt;
  logic sel;
  logic first;
  // Both lines released at start, so the pull-ups decide the level
  initial begin
    scl_rel_out = 1'b1;
    sda_rel_out = 1'b1;
    last_byte_out = 8'h00;
    sh = 8'h00;
    cnt = 0;
    sel = 1'b0;
    first = 1'b0;
  end
  // START or repeated START restarts byte framing
  always @(negedge sda_in) begin
    if (scl_in) begin
      cnt = 0;
      first = 1'b1;
      sel = 1'b0;
    end
  end
  // STOP drops selection
  always @(posedge sda_in) begin
    if (scl_in) begin
      cnt = 0;
      sel = 1'b0;
    end
  end
  // Bits arrive MSB first, taken while the clock is high
  always @(posedge scl_in) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda_in};
      cnt++;
    end
  end
  // Acknowledge is driven from the falling edge after the eighth bit to the falling edge after the ninth
  always @(negedge scl_in) begin
    if (cnt == 8) begin
      last_byte_out = sh;
      if (first) begin
        sel = (sh[7:1] == ADDR || sh[7:3] == 5'h1e) && !sh[0];
      end
      sda_rel_out = !(sel && ack_en_in);
      cnt = 9;
    end else if (cnt == 9) begin
      sda_rel_out = 1'b1;
      cnt = 0;
      first = 1'b0;
      if (stretch_in) begin
        scl_rel_out = 1'b0;
        #3000;
        scl_rel_out = 1'b1;
      end
    end
  end
endmodule

// *** verif/i2c_master_transmit_sequencer_tb.sv ***
// Self-checking bench for the two-wire master transmit sequencer
`timescale 1ns/1ps
module i2c_master_transmit_sequencer_tb;
  import imt_pkg::*;
  localparam logic [6:0] PEER = 7'h2a;
  logic clk_in;
  logic resetn_in;
  logic begin_set, stop_set, flag_clear, byte_wr, ack_en, stretch, arb_low;
  logic [7:0] byte_d;
  logic scl_oe_n, sda_oe_n, s_scl_rel, s_sda_rel, begin_req, stop_req, flag, irq, busy;
  logic [7:0] code, peer_byte;
  wire logic scl_w;
  wire logic sda_w;
  int fail_count = 0;
  int tests_run = 0;
  // Open-drain wires: any party pulling low wins, pull-ups otherwise
  assign scl_w = scl_oe_n & s_scl_rel;
  assign sda_w = sda_oe_n & s_sda_rel & ~arb_low;
  always #20 clk_in = ~clk_in;
  imt_sequencer DUT (.clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_w), .scl_out(),
    .scl_oe_n_out(scl_oe_n), .sda_in(sda_w), .sda_out(), .sda_oe_n_out(sda_oe_n),
    .begin_set_in(begin_set), .stop_set_in(stop_set), .flag_clear_in(flag_clear), .byte_wr_in(byte_wr),
    .byte_in(byte_d), .acknowledge_enable_in(ack_en), .general_call_enable_in(1'b0),
    .own_address_in(7'h15), .begin_condition_request_out(begin_req), .stop_condition_request_out(stop_req),
    .transfer_event_flag_out(flag), .irq_out(irq), .state_code_out(code), .rx_byte_out(), .bus_busy_out(busy));
  imt_slave_model #(.ADDR(PEER)) peer (.scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en),
    .stretch_in(stretch), .scl_rel_out(s_scl_rel), .sda_rel_out(s_sda_rel), .last_byte_out(peer_byte));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // Software writes stand for one cycle, taken at the next rising edge
  task automatic sw(input logic b, input logic s, input logic c, input logic w, input logic [7:0] d);
    begin_set = b;
    stop_set = s;
    flag_clear = c;
    byte_wr = w;
    byte_d = d;
    @(negedge clk_in);
    begin_set = 1'b0;
    stop_set = 1'b0;
    flag_clear = 1'b0;
    byte_wr = 1'b0;
  endtask
  // Bounded wait for the event flag, then compare the posted code
  task automatic step(input logic b, input logic s, input logic w, input logic [7:0] d, input logic [7:0] exp);
    int n;
    n = 0;
    sw(b, s, 1'b1, w, d);
    while (flag !== 1'b1 && n < 20000) begin
      @(negedge clk_in);
      n++;
    end
    check(code, exp);
  endtask
  function automatic logic [7:0] exp_data(input logic a);
    return a ? CODE_DATA_ACK : CODE_DATA_NACK;
  endfunction
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic a;
    logic [7:0] d;
    int n;
    clk_in = 1'b0;
    resetn_in = 1'b0;
    ack_en = 1'b1;
    stretch = 1'b0;
    arb_low = 1'b0;
    byte_d = 8'h00;
    begin_set = 1'b0;
    stop_set = 1'b0;
    flag_clear = 1'b0;
    byte_wr = 1'b0;
    void'($urandom(32'hb572_4181));
    repeat (8) @(negedge clk_in);
    resetn_in = 1'b1;
    check({5'h00, flag, scl_oe_n, sda_oe_n}, 8'h03);
    sw(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    check({7'h00, begin_req}, 8'h01);
    step(1'b0, 1'b0, 1'b0, 8'h00, CODE_START);
    check({5'h00, begin_req, irq, scl_oe_n}, 8'h02);
    repeat (300) @(negedge clk_in);
    check({5'h00, flag, scl_oe_n, code == CODE_START}, 8'h05);
    step(1'b0, 1'b0, 1'b1, {PEER, 1'b0}, CODE_ADDR_ACK);
    // Random data bytes with the peer answering ACK or NACK at random
    for (int i = 0; i < 3; i++) begin
      a = 1'($urandom_range(1, 0));
      d = 8'($urandom);
      ack_en = a;
      step(1'b0, 1'b0, 1'b1, d, exp_data(a));
      check(peer_byte, d);
    end
    step(1'b1, 1'b0, 1'b0, 8'h00, CODE_RSTART);
    ack_en = 1'b1;
    step(1'b0, 1'b0, 1'b1, {~PEER, 1'b0}, CODE_ADDR_NACK);
    step(1'b1, 1'b1, 1'b0, 8'h00, CODE_START);
    check({6'h00, begin_req, stop_req}, 8'h00);
    step(1'b0, 1'b0, 1'b1, 8'hf0, CODE_ADDR_ACK);
    step(1'b0, 1'b0, 1'b1, 8'h5c, CODE_XADDR_ACK);
    // Slow peer stretches the clock after each acknowledge
    stretch = 1'b1;
    d = 8'($urandom);
    step(1'b0, 1'b0, 1'b1, d, CODE_DATA_ACK);
    stretch = 1'b0;
    // A rival holds the data line low while a byte of ones goes out
    arb_low = 1'b1;
    step(1'b0, 1'b0, 1'b1, 8'hff, CODE_ARB);
    repeat (4) @(negedge clk_in);
    arb_low = 1'b0;
    repeat (10) @(negedge clk_in);
    sw(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    repeat (2) @(negedge clk_in);
    check({5'h00, flag, busy, scl_oe_n}, 8'h01);
    step(1'b1, 1'b0, 1'b0, 8'h00, CODE_START);
    step(1'b0, 1'b0, 1'b1, {PEER, 1'b0}, CODE_ADDR_ACK);
    sw(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    n = 0;
    while (stop_req !== 1'b0 && n < 5000) begin
      @(negedge clk_in);
      n++;
    end
    repeat (10) @(negedge clk_in);
    check({3'h0, busy, stop_req, flag, scl_w, sda_w}, 8'h03);
    test_done();
  end
  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    test_done();
  end
endmodule
